// ### rtl/pin_trig_regs.svh
// constants for the analog pin mode and trigger routing block
// assumes a plain address/strobe register port with 20-bit byte addresses
`ifndef PIN_TRIG_REGS_SVH
`define PIN_TRIG_REGS_SVH
// ****************************************
// register offsets
// ****************************************
`define ADDR_PORT0_DIR 20'hfff20
`define ADDR_PORT2_DIR 20'hfff22
`define ADDR_PORT14_DIR 20'hfff2e
`define ADDR_ANALOG_SEL 20'hf0076
`define ADDR_PORT0_ASEL 20'hf0060
`define ADDR_PORT14_ASEL 20'hf006e
`define ADDR_FUNC_SEL 20'hf05c6
`define ADDR_EDGE_SEL 20'hf05d0
`define ADDR_CMP_CTRL 20'hf05d1
`define ADDR_PIN_IN0 20'hf05d2
`define ADDR_PIN_IN2 20'hf05d3
`define ADDR_PIN_IN14 20'hf05d4
// ****************************************
// reset values and fixed bits
// ****************************************
`define DIR_RESET 8'hff
`define ASEL_RESET 8'hff
`define ZERO_RESET 8'h00
`define PORT0_FIXED 8'h93
`define PORT2_FIXED 8'h08
`define PORT14_FIXED 8'h7f
// ****************************************
// field positions
// ****************************************
`define FS_RST0 0
`define FS_RST1 1
`define FS_NF_BYP 4
`define FS_CMP0 5
`define FS_CMP2 6
`define P0_ANA_BIT 3
`define P14_ANA_BIT 7
`define ASEL_W 4
// ****************************************
// timing
// ****************************************
`define CLK_PERIOD_NS 100
`define IRQ_WIDTH_NS 1000
`endif

// ### rtl/pin_trig_pkg.sv
// types shared by the pin and trigger routing block
// assumes the constants header is included by the users
package pin_trig_pkg;
   // edge detector state, gray along idle-armed-fired
   typedef enum logic [1:0] {
      edge_idle = 2'b00,
      edge_armed = 2'b01,
      edge_fired = 2'b11
   } edge_state_e;
   typedef logic [7:0] byte_t;
endpackage

// ### rtl/trig_sync.sv
// two-stage synchroniser for one trigger level
// assumes the input is a level from outside the clock domain
module trig_sync import pin_trig_pkg::*; (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic async_in,
   output logic sync_out
);
   logic stage1;
   // first stage feeds only the second
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         stage1 <= 1'b0;
         sync_out <= 1'b0;
      end else begin
         stage1 <= async_in;
         sync_out <= stage1;
      end
   end
endmodule // trig_sync

// ### rtl/edge_detect.sv
// selectable rising/falling edge detector with a small state record
// assumes a synchronised input level
module edge_detect import pin_trig_pkg::*; (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic level_in,
   input wire logic rise_en,
   input wire logic fall_en,
   output logic pulse
);
   logic prev;
   edge_state_e state;
   wire rise = level_in & ~prev;
   wire fall = ~level_in & prev;
   wire hit = (rise & rise_en) | (fall & fall_en);
   assign pulse = hit;
   // remember last level and arming state
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         prev <= 1'b0;
         state <= edge_idle;
      end else begin
         prev <= level_in;
         case (state)
            edge_idle: state <= (rise_en | fall_en) ? edge_armed : edge_idle;
            edge_armed: state <= hit ? edge_fired : ((rise_en | fall_en) ? edge_armed : edge_idle);
            edge_fired: state <= edge_armed;
            default: state <= edge_idle;
         endcase
      end
   end
endmodule // edge_detect

// ### rtl/pin_trig_route.sv
// analog pin mode registers and trigger routing to irq, stop release,
// forced output stop and timer restart
// assumes core_clk is the system or pll clock and register port inputs are synchronous
//
// Chosen here: strobed register access.
`include "pin_trig_regs.svh"
// How it works
// - direction bit 0 drives output buffer, 1 turns it off for input
// - a pin with direction 0 is never an analog input
// - reset presets direction registers to all ones; whole-byte writes
// - pin read returns zero while the pin is an analog input
// - port-2 pins: digital in, digital out, analog in; analog with output banned
// - port 0 bit 3 and port 14 bit 7 select mode the same way
// - function select 0 makes pins edge irqs that release stop
// - only pin a drives second forced stop, active high, edges irq only
// - pin forced stop is direct; restart adds sync latency plus one clock
// - filter bypass on pin a shortens the analog filter width; here the FS_NF_BYP bit is stored but drives nothing
// - cycle counts are in core_clk, system or pll clock
// - comparators 0 and 2 direct path sees rising edge only
// - comparators 0 and 2 via edge circuit cannot release stop
// - comparator filter setting adds its width to the needed width
// - comparator forced stop request is active while high
// - timer output changes after a further output delay
// - comparators 1 and 3, and 2 with stop-path select 0, request restart; all six irq, 0 and 2 stop only with stop-path select 1
// - function select 1 routes pin to restart or stop, no stop release
// - stop-path select 1 routes the request to irq; 0 uses edge circuit
module pin_trig_route import pin_trig_pkg::*; #(
   parameter int NCMP = 6
) (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic [19:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic [7:0] port0_pin_in,
   input wire logic [7:0] port2_pin_in,
   input wire logic [7:0] port14_pin_in,
   output logic [7:0] port0_out_en,
   output logic [7:0] port2_out_en,
   output logic [7:0] port14_out_en,
   output logic [7:0] port2_analog_in,
   output logic port0_analog_in,
   output logic port14_analog_in,
   input wire logic ext_irq_pin_a,
   input wire logic ext_irq_pin_b,
   input wire logic [NCMP-1:0] cmp_out,
   output logic irq_pin_a,
   output logic irq_pin_b,
   output logic [NCMP-1:0] cmp_detect_irq,
   output logic stop_release,
   output logic forced_stop_req,
   output logic forced_stop2_req,
   output logic restart_req
);
   // ****************************************
   // registers
   // ****************************************
   byte_t port0_direction, port2_direction, port14_direction;
   logic [`ASEL_W-1:0] analog_pin_select;
   byte_t port0_analog_select, port14_analog_select;
   byte_t func_sel, edge_sel, cmp_ctrl;

   // write decode
   wire wr_p0 = reg_wr && (reg_addr == `ADDR_PORT0_DIR);
   wire wr_p2 = reg_wr && (reg_addr == `ADDR_PORT2_DIR);
   wire wr_p14 = reg_wr && (reg_addr == `ADDR_PORT14_DIR);
   wire wr_asel = reg_wr && (reg_addr == `ADDR_ANALOG_SEL);
   wire wr_pa0 = reg_wr && (reg_addr == `ADDR_PORT0_ASEL);
   wire wr_pa14 = reg_wr && (reg_addr == `ADDR_PORT14_ASEL);
   wire wr_fs = reg_wr && (reg_addr == `ADDR_FUNC_SEL);
   wire wr_es = reg_wr && (reg_addr == `ADDR_EDGE_SEL);
   wire wr_cc = reg_wr && (reg_addr == `ADDR_CMP_CTRL);

   // direction registers preset to inputs; fixed bits stay one
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         port0_direction <= `DIR_RESET;
         port2_direction <= `DIR_RESET;
         port14_direction <= `DIR_RESET;
      end else begin
         if (wr_p0) port0_direction <= reg_wdata | `PORT0_FIXED;
         if (wr_p2) port2_direction <= reg_wdata | `PORT2_FIXED;
         if (wr_p14) port14_direction <= reg_wdata | `PORT14_FIXED;
      end
   end

   // mode and routing controls
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         analog_pin_select <= '0;
         port0_analog_select <= `ASEL_RESET;
         port14_analog_select <= `ASEL_RESET;
         func_sel <= `ZERO_RESET;
         edge_sel <= `ZERO_RESET;
         cmp_ctrl <= `ZERO_RESET;
      end else begin
         if (wr_asel) analog_pin_select <= reg_wdata[`ASEL_W-1:0];
         if (wr_pa0) port0_analog_select <= reg_wdata;
         if (wr_pa14) port14_analog_select <= reg_wdata;
         if (wr_fs) func_sel <= reg_wdata;
         if (wr_es) edge_sel <= reg_wdata;
         if (wr_cc) cmp_ctrl <= reg_wdata;
      end
   end

   // ****************************************
   // pin modes
   // ****************************************
   // port-2 analog pins from the channel select code
   logic [7:0] p2_asel;
   always_comb begin
      p2_asel = 8'h00;
      case (analog_pin_select)
         4'h0: p2_asel = 8'hff;
         4'h2: p2_asel = 8'h01;
         4'h3: p2_asel = 8'h03;
         4'h4: p2_asel = 8'h07;
         4'h5: p2_asel = 8'h07;
         4'h6: p2_asel = 8'h17;
         4'h7: p2_asel = 8'h37;
         4'h8: p2_asel = 8'h77;
         4'h9: p2_asel = 8'hff;
         4'hf: p2_asel = 8'hff;
         default: p2_asel = 8'h00;
      endcase
   end

   // output buffer on only when direction is 0
   assign port0_out_en = ~port0_direction;
   assign port2_out_en = ~port2_direction;
   assign port14_out_en = ~port14_direction;
   // analog only with input mode
   // bit 3 has no pin, so it is never an analog input
   assign port2_analog_in = p2_asel & port2_direction & ~`PORT2_FIXED;
   assign port0_analog_in = port0_analog_select[`P0_ANA_BIT] & port0_direction[`P0_ANA_BIT];
   assign port14_analog_in = port14_analog_select[`P14_ANA_BIT] & port14_direction[`P14_ANA_BIT];

   // pin read masks analog pins to zero
   wire [7:0] p0_rd_mask = {4'h0, port0_analog_in, 3'h0};
   wire [7:0] p14_rd_mask = {port14_analog_in, 7'h00};
   wire [7:0] p0_read = port0_pin_in & ~p0_rd_mask;
   wire [7:0] p2_read = port2_pin_in & ~port2_analog_in;
   wire [7:0] p14_read = port14_pin_in & ~p14_rd_mask;

   // ****************************************
   // read port
   // ****************************************
   wire [7:0] rd_mux =
      (reg_addr == `ADDR_PORT0_DIR) ? port0_direction :
      (reg_addr == `ADDR_PORT2_DIR) ? port2_direction :
      (reg_addr == `ADDR_PORT14_DIR) ? port14_direction :
      (reg_addr == `ADDR_ANALOG_SEL) ? {4'h0, analog_pin_select} :
      (reg_addr == `ADDR_PORT0_ASEL) ? port0_analog_select :
      (reg_addr == `ADDR_PORT14_ASEL) ? port14_analog_select :
      (reg_addr == `ADDR_FUNC_SEL) ? func_sel :
      (reg_addr == `ADDR_EDGE_SEL) ? edge_sel :
      (reg_addr == `ADDR_CMP_CTRL) ? cmp_ctrl :
      (reg_addr == `ADDR_PIN_IN0) ? p0_read :
      (reg_addr == `ADDR_PIN_IN2) ? p2_read :
      (reg_addr == `ADDR_PIN_IN14) ? p14_read : 8'h00;

   // read data valid one cycle after the strobe only
   always_ff @(posedge core_clk) begin
      if (!rst_b) reg_rdata <= 8'h00;
      else reg_rdata <= reg_rd ? rd_mux : 8'h00;
   end

   // ****************************************
   // trigger routing
   // ****************************************
   wire pin_a_s, pin_b_s;
   wire [NCMP-1:0] cmp_s, cmp_edge;
   wire pin_a_edge, pin_b_edge;

   // synchronise the pin triggers
   trig_sync u_sync_a (.core_clk(core_clk), .rst_b(rst_b), .async_in(ext_irq_pin_a), .sync_out(pin_a_s));
   trig_sync u_sync_b (.core_clk(core_clk), .rst_b(rst_b), .async_in(ext_irq_pin_b), .sync_out(pin_b_s));
   edge_detect u_edge_a (.core_clk(core_clk), .rst_b(rst_b), .level_in(pin_a_s),
      .rise_en(edge_sel[0]), .fall_en(edge_sel[1]), .pulse(pin_a_edge));
   edge_detect u_edge_b (.core_clk(core_clk), .rst_b(rst_b), .level_in(pin_b_s),
      .rise_en(edge_sel[2]), .fall_en(edge_sel[3]), .pulse(pin_b_edge));

   // per comparator: polarity invert then sync and edge
   genvar gi;
   generate
      for (gi = 0; gi < NCMP; gi++) begin : g_cmp
         trig_sync u_sync (.core_clk(core_clk), .rst_b(rst_b),
            .async_in(cmp_out[gi] ^ cmp_ctrl[gi]), .sync_out(cmp_s[gi]));
         edge_detect u_edge (.core_clk(core_clk), .rst_b(rst_b), .level_in(cmp_s[gi]),
            .rise_en(edge_sel[4]), .fall_en(edge_sel[5]), .pulse(cmp_edge[gi]));
      end
   endgenerate

   wire [NCMP-1:0] cmp_req = cmp_out ^ cmp_ctrl[NCMP-1:0]; // level, active high
   logic cmp0_prev, cmp2_prev, restart_pend;

   // direct-path rising detect for comparators 0 and 2
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         cmp0_prev <= 1'b0;
         cmp2_prev <= 1'b0;
      end else begin
         cmp0_prev <= cmp_s[0];
         cmp2_prev <= cmp_s[2];
      end
   end
   wire cmp0_rise = cmp_s[0] & ~cmp0_prev;
   wire cmp2_rise = cmp_s[2] & ~cmp2_prev;

   // comparator interrupts: for 0 and 2 the stop-path select picks direct or edge circuit
   always_comb begin
      cmp_detect_irq = cmp_edge;
      cmp_detect_irq[0] = func_sel[`FS_CMP0] ? cmp0_rise : cmp_edge[0];
      cmp_detect_irq[2] = func_sel[`FS_CMP2] ? cmp2_rise : cmp_edge[2];
   end

   // pin interrupts and stop release
   assign irq_pin_a = pin_a_edge;
   assign irq_pin_b = pin_b_edge;
   assign stop_release = (~func_sel[`FS_RST0] & pin_a_edge) | (~func_sel[`FS_RST1] & pin_b_edge)
      | (func_sel[`FS_CMP0] & cmp0_rise) | (func_sel[`FS_CMP2] & cmp2_rise);

   // forced stop requests: direct levels, no clocking
   assign forced_stop2_req = func_sel[`FS_RST0] & ext_irq_pin_a;
   // filter width and output delay lie outside this block; the level passes unclocked
   assign forced_stop_req = |(cmp_req & {1'b1, 1'b1, 1'b1, func_sel[`FS_CMP2], 1'b1, func_sel[`FS_CMP0]});

   // restart request registered one more clock after edge
   wire restart_hit = (func_sel[`FS_RST0] & pin_a_edge) | (func_sel[`FS_RST1] & pin_b_edge)
      | cmp_edge[1] | cmp_edge[3] | (~func_sel[`FS_CMP2] & cmp_edge[2]);
   always_ff @(posedge core_clk) begin
      if (!rst_b) restart_pend <= 1'b0;
      else restart_pend <= restart_hit;
   end
   assign restart_req = restart_pend;

   // ****************************************
   // checks
   // ****************************************
   property p_dir_reset;
      @(posedge core_clk) $rose(rst_b) |-> (port0_direction == 8'hff && port2_direction == 8'hff);
   endproperty
   a_dir_reset: assert property (p_dir_reset) else $error("direction not preset");
   property p_out_en;
      @(posedge core_clk) disable iff (!rst_b) port2_out_en[1] |-> !port2_direction[1];
   endproperty
   a_out_en: assert property (p_out_en) else $error("buffer on in input mode");
   property p_analog_dir;
      @(posedge core_clk) disable iff (!rst_b) port2_analog_in[2] |-> port2_direction[2];
   endproperty
   a_analog_dir: assert property (p_analog_dir) else $error("analog in output mode");
   property p_fixed;
      @(posedge core_clk) disable iff (!rst_b) port14_direction[6:0] == 7'h7f;
   endproperty
   a_fixed: assert property (p_fixed) else $error("fixed bit lost");
   property p_read_zero;
      @(posedge core_clk) disable iff (!rst_b)
         (reg_rd && reg_addr == `ADDR_PIN_IN2 && port2_analog_in[7]) |=> !reg_rdata[7];
   endproperty
   a_read_zero: assert property (p_read_zero) else $error("analog pin read nonzero");
   property p_stop2;
      @(posedge core_clk) disable iff (!rst_b) forced_stop2_req |-> (ext_irq_pin_a && func_sel[0]);
   endproperty
   a_stop2: assert property (p_stop2) else $error("stop2 without pin a");
   property p_restart;
      @(posedge core_clk) disable iff (!rst_b) restart_hit |=> restart_req;
   endproperty
   a_restart: assert property (p_restart) else $error("restart not one clock later");
   property p_no_release;
      @(posedge core_clk) disable iff (!rst_b)
         (func_sel[0] && func_sel[1] && !func_sel[5] && !func_sel[6]) |-> !stop_release;
   endproperty
   a_no_release: assert property (p_no_release) else $error("stop release while disabled");
endmodule // pin_trig_route

// ### dv/tb.sv
// self-checking bench for the pin mode and trigger routing block
// assumes the rtl package, constants header and design module are compiled first
`include "pin_trig_regs.svh"
module tb import pin_trig_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   // ****************************************
   // signals
   // ****************************************
   logic core_clk, rst_b, reg_wr, reg_rd, rd_d, a_d;
   logic [19:0] reg_addr;
   byte_t reg_wdata, reg_rdata, p0_oe, p2_oe, p14_oe, p2_ana, rd_q[$], mk_q[$];
   logic p0_ana, p14_ana, irq_a, irq_b, stop_rel, fstop, fstop2, restart;
   logic [7:0] trg;
   logic [5:0] cmp_irq;
   logic [15:0] lfsr;
   int failures, checked, cyc, t_a0, d_a, n_rst, n_stop, cnt[8];
   pin_trig_route #(.NCMP(6)) pin_trig_route_inst (.core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .port0_pin_in(8'hff),
      .port2_pin_in(8'hff), .port14_pin_in(8'hff), .port0_out_en(p0_oe), .port2_out_en(p2_oe),
      .port14_out_en(p14_oe), .port2_analog_in(p2_ana), .port0_analog_in(p0_ana), .port14_analog_in(p14_ana),
      .ext_irq_pin_a(trg[0]), .ext_irq_pin_b(trg[1]), .cmp_out(trg[7:2]), .irq_pin_a(irq_a), .irq_pin_b(irq_b),
      .cmp_detect_irq(cmp_irq), .stop_release(stop_rel), .forced_stop_req(fstop), .forced_stop2_req(fstop2),
      .restart_req(restart));
   // ****************************************
   // clock and watchdog
   // ****************************************
   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end
   initial begin
      repeat (20000) @(posedge core_clk);
      failures++;
      end_of_test();
   end
   // ****************************************
   // helpers
   // ****************************************
   function automatic logic [15:0] lfsr_next(logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task automatic chk(string what, byte_t exp, byte_t got);
      checked++;
      if (got !== exp) begin
         failures++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic chk_n(string what, int exp, int got);
      checked++;
      if (got != exp) begin
         failures++;
         $display("BAD %s expected %0d seen %0d", what, exp, got);
      end
   endtask
   // one bus cycle: write, or read with expected value and compare mask
   task automatic acc(bit w, logic [19:0] a, byte_t d, byte_t m = 8'hff);
      reg_addr <= a;
      reg_wdata <= w ? d : 8'h00;
      reg_wr <= w;
      reg_rd <= !w;
      if (!w) begin
         rd_q.push_back(d & m);
         mk_q.push_back(m);
      end
      @(posedge core_clk);
   endtask
   task automatic idle(int n);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      repeat (n) @(posedge core_clk);
   endtask
   // move one trigger line and count what comes out; a negative restart or stop figure is not checked
   task automatic hit(int i, bit v, int ei, int er, int es);
      int bi, br, bs;
      bi = cnt[i];
      br = n_rst;
      bs = n_stop;
      trg[i] <= v;
      repeat (5) @(posedge core_clk);
      chk_n("irq count", ei, cnt[i] - bi);
      if (er >= 0) chk_n("restart count", er, n_rst - br);
      if (es >= 0) chk_n("stop release count", es, n_stop - bs);
   endtask
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // ****************************************
   // monitor: read data and pulse counts
   // ****************************************
   always @(posedge core_clk) begin
      if (rd_d) chk("reg_rdata", rd_q.pop_front(), reg_rdata & mk_q.pop_front());
      rd_d <= reg_rd;
      cyc++;
      if (trg[0] && !a_d) t_a0 = cyc;
      a_d = trg[0];
      if (irq_a) d_a = cyc - t_a0;
      cnt[0] += irq_a;
      cnt[1] += irq_b;
      for (int k = 0; k < 6; k++) cnt[k + 2] += cmp_irq[k];
      n_rst += restart;
      n_stop += stop_rel;
   end
   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      rst_b = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0; rd_d = 1'b0; a_d = 1'b0;
      reg_addr = 20'h00000; reg_wdata = 8'h00; trg = 8'h00; lfsr = 16'h5ccc;
      repeat (3) @(posedge core_clk);
      rst_b <= 1'b1;
      @(posedge core_clk);
      chk("out_en", 8'h00, p0_oe | p2_oe | p14_oe);
      acc(0, `ADDR_PORT0_DIR, 8'hff);
      acc(0, `ADDR_PORT2_DIR, 8'hff);
      acc(0, `ADDR_PORT14_DIR, 8'hff);
      acc(0, 20'h00123, 8'h00);
      idle(2);
      $display("done reset values");
      for (int i = 0; i < 12; i++) begin
         lfsr = lfsr_next(lfsr);
         case (i % 3)
            0: begin
               acc(1, `ADDR_PORT0_DIR, lfsr[7:0]);
               acc(0, `ADDR_PORT0_DIR, lfsr[7:0] | `PORT0_FIXED);
               chk("port0_out_en", ~(lfsr[7:0] | `PORT0_FIXED), p0_oe);
            end
            1: begin
               acc(1, `ADDR_PORT2_DIR, lfsr[7:0]);
               acc(0, `ADDR_PORT2_DIR, lfsr[7:0] | `PORT2_FIXED);
               chk("port2_out_en", ~(lfsr[7:0] | `PORT2_FIXED), p2_oe);
            end
            default: begin
               acc(1, `ADDR_PORT14_DIR, lfsr[7:0]);
               acc(0, `ADDR_PORT14_DIR, lfsr[7:0] | `PORT14_FIXED);
               chk("port14_out_en", ~(lfsr[7:0] | `PORT14_FIXED), p14_oe);
            end
         endcase
      end
      $display("done direction writes");
      acc(1, `ADDR_PORT0_DIR, 8'hff);
      acc(1, `ADDR_PORT14_DIR, 8'hff);
      acc(1, `ADDR_PORT2_DIR, 8'hff);
      idle(1);
      chk("analog 0/14", 8'h03, {6'h00, p0_ana, p14_ana});
      acc(0, `ADDR_PIN_IN0, 8'h00, 8'h08);
      acc(0, `ADDR_PIN_IN14, 8'h00, 8'h80);
      acc(1, `ADDR_PORT0_DIR, 8'h00);
      idle(1);
      chk("port0_analog_in", 8'h00, {7'h00, p0_ana});
      acc(1, `ADDR_PORT0_DIR, 8'hff);
      acc(1, `ADDR_PORT0_ASEL, 8'h00);
      idle(1);
      chk("port0_analog_in", 8'h00, {7'h00, p0_ana});
      acc(0, `ADDR_PIN_IN0, 8'h08, 8'h08);
      acc(1, `ADDR_ANALOG_SEL, 8'h01);
      idle(1);
      chk("port2_analog_in", 8'h00, p2_ana);
      acc(1, `ADDR_ANALOG_SEL, 8'h00);
      idle(1);
      chk("port2_analog_in bit2", 8'h04, p2_ana & 8'h04);
      acc(0, `ADDR_PIN_IN2, 8'h00, 8'h04);
      acc(1, `ADDR_PORT2_DIR, 8'h00);
      idle(1);
      chk("port2_analog_in", 8'h00, p2_ana);
      $display("done analog modes");
      acc(1, `ADDR_EDGE_SEL, 8'h15);
      acc(1, `ADDR_FUNC_SEL, 8'h00);
      idle(1);
      hit(0, 1'b1, 1, 0, 1);
      chk_n("irq delay in range", 1, int'(d_a >= 2 && d_a <= 3));
      hit(0, 1'b0, 0, 0, 0);
      acc(1, `ADDR_FUNC_SEL, 8'h01);
      idle(1);
      hit(0, 1'b1, 1, 1, 0);
      chk("forced_stop2_req", 8'h01, {7'h00, fstop2});
      hit(0, 1'b0, 0, 0, 0);
      chk("forced_stop2_req", 8'h00, {7'h00, fstop2});
      acc(1, `ADDR_EDGE_SEL, 8'h02);
      idle(1);
      hit(0, 1'b1, 0, -1, 0);
      chk("forced_stop2_req", 8'h01, {7'h00, fstop2});
      hit(0, 1'b0, 1, -1, 0);
      acc(1, `ADDR_EDGE_SEL, 8'h15);
      acc(1, `ADDR_FUNC_SEL, 8'h02);
      idle(1);
      hit(1, 1'b1, 1, 1, 0);
      chk("forced_stop2_req", 8'h00, {7'h00, fstop2});
      hit(1, 1'b0, 0, 0, 0);
      $display("done pin triggers");
      acc(1, `ADDR_FUNC_SEL, 8'h00);
      acc(1, `ADDR_EDGE_SEL, 8'h10);
      idle(1);
      for (int k = 1; k < 6; k++) begin
         if (k == 2) continue;
         hit(k + 2, 1'b1, 1, int'(k == 1 || k == 3), 0);
         chk("forced_stop_req", 8'h01, {7'h00, fstop});
         hit(k + 2, 1'b0, 0, 0, 0);
         chk("forced_stop_req", 8'h00, {7'h00, fstop});
      end
      acc(1, `ADDR_FUNC_SEL, 8'h20);
      acc(1, `ADDR_EDGE_SEL, 8'h20);
      idle(1);
      hit(2, 1'b1, 1, -1, -1);
      hit(2, 1'b0, 0, -1, -1);
      acc(1, `ADDR_FUNC_SEL, 8'h00);
      idle(1);
      hit(2, 1'b1, 0, -1, 0);
      hit(2, 1'b0, 1, -1, 0);
      acc(1, `ADDR_FUNC_SEL, 8'h20);
      idle(1);
      hit(2, 1'b1, 1, -1, -1);
      acc(1, `ADDR_CMP_CTRL, 8'h01);
      idle(3);
      hit(2, 1'b0, 1, -1, -1);
      // end of comparator use: edge detection off before the test ends
      acc(1, `ADDR_EDGE_SEL, 8'h00);
      $display("done comparator triggers");
      idle(3);
      end_of_test();
   end
endmodule // tb
